//--- design/bp_bus_defs.svh
`ifndef BP_BUS_DEFS_SVH
`define BP_BUS_DEFS_SVH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define ADDR_W 22
`define DATA_LO_W 16
`define IO_PAGE_TOP 22'h3fe000
`define BIDIR_LINES 42
`define UNIDIR_LINES 2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_PS 8000
`define TIMEOUT_NS 10000
`define TIMEOUT_CYC ((`TIMEOUT_NS * 1000) / `CLK_PERIOD_PS)
`define TMO_W 12

`endif

//--- design/bp_bus_pkg.sv
package bp_bus_pkg;
   // master cycle sequencer states
   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_sync,
      st_strobe,
      st_release,
      st_abort
   } cyc_state_t;
   // arbitration owner
   typedef enum logic [1:0] {
      own_cpu,
      own_dma,
      own_intr
   } owner_t;
endpackage

//--- design/reply_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "bp_bus_defs.svh"

// ----------------------------------------------------------------------
// reply watchdog: counts local clocks while a cycle waits for reply
// ----------------------------------------------------------------------
module reply_timer #(
   parameter int W = `TMO_W
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic start,
   input wire logic run,
   input wire logic [W-1:0] limit,
   output logic expired
);
   logic [W-1:0] count; // elapsed clocks

   // restarts at cycle start, frozen by reply
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         count <= '0;
         expired <= 1'b0;
      end else if (clk_en) begin
         if (start) begin
            count <= '0;
            expired <= 1'b0;
         end else if (run && !expired) begin
            if (count >= limit - W'(1)) begin
               expired <= 1'b1;
            end else begin
               count <= count + W'(1);
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- design/bp_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "bp_bus_defs.svh"

module bp_bus_master
   import bp_bus_pkg::*;
#(
   parameter logic [`TMO_W-1:0] TIMEOUT_CYC = `TMO_W'(`TIMEOUT_CYC)
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   // user side
   input wire logic req,
   input wire logic req_write,
   input wire logic [`ADDR_W-1:0] req_addr,
   input wire logic [15:0] req_wdata,
   input wire logic [`TMO_W-1:0] tmo_limit,
   input wire logic err_clear,
   input wire logic dma_request,
   input wire logic intr_request,
   output logic busy,
   output logic done,
   output logic [17:0] rdata,
   output logic timeout_err,
   output logic dma_granted,
   // bus side, asserted high = line pulled low
   input wire logic [`ADDR_W-1:0] dal_in,
   output logic [`ADDR_W-1:0] dal_out,
   output logic [`ADDR_W-1:0] dal_oe,
   input wire logic sync_in,
   output logic sync_out,
   output logic sync_oe,
   output logic din_out,
   output logic din_oe,
   output logic dout_out,
   output logic dout_oe,
   output logic wtbt_out,
   output logic wtbt_oe,
   output logic iosel_out,
   output logic iosel_oe,
   input wire logic reply_in,
   input wire logic sack_in,
   output logic iak_chain_out,
   output logic dmg_chain_out
);
   // ----------------------------------------------------------------------
   // local state
   // ----------------------------------------------------------------------
   cyc_state_t state; // cycle sequencer
   owner_t owner; // current bus owner
   logic tmo_start; // restart watchdog
   logic tmo_hit; // watchdog expired
   logic wr_cyc; // latched direction
   logic [`TMO_W-1:0] limit_eff; // enforced limit

   // i/o page decode, used for the iosel line and for the assertion
   function automatic logic in_io_page(input logic [`ADDR_W-1:0] a);
      return a >= `IO_PAGE_TOP;
   endfunction

   // never let software go below the 10 us floor
   always_comb begin
      if (tmo_limit > TIMEOUT_CYC) begin
         limit_eff = tmo_limit;
      end else begin
         limit_eff = TIMEOUT_CYC;
      end
   end

   // ----------------------------------------------------------------------
   // arbitration: cpu owns unless it grants one chain
   // ----------------------------------------------------------------------
   // grants change only between cycles, so one master stays on the bus
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         owner <= own_cpu;
         iak_chain_out <= 1'b0;
         dmg_chain_out <= 1'b0;
         dma_granted <= 1'b0;
      end else if (clk_en) begin
         case (owner)
            own_cpu: begin
               if (state == st_idle && !req && !sync_in) begin
                  if (intr_request) begin
                     owner <= own_intr;
                     iak_chain_out <= 1'b1;
                  end else if (dma_request) begin
                     owner <= own_dma;
                     dmg_chain_out <= 1'b1;
                     dma_granted <= 1'b1;
                  end
               end
            end
            own_dma: begin
               // grant drops once the chain winner takes the bus
               if (sack_in) begin
                  dmg_chain_out <= 1'b0;
               end
               if (!sack_in && !dmg_chain_out && !sync_in) begin
                  owner <= own_cpu;
                  dma_granted <= 1'b0;
               end
            end
            own_intr: begin
               // nearest requester keeps acknowledge, is its duty
               if (!intr_request) begin
                  owner <= own_cpu;
                  iak_chain_out <= 1'b0;
               end
            end
            default: begin
               owner <= own_cpu;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // cycle sequencer
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state <= st_idle;
         wr_cyc <= 1'b0;
         dal_out <= '0;
         dal_oe <= '0;
         sync_out <= 1'b0;
         sync_oe <= 1'b0;
         din_out <= 1'b0;
         din_oe <= 1'b0;
         dout_out <= 1'b0;
         dout_oe <= 1'b0;
         wtbt_out <= 1'b0;
         wtbt_oe <= 1'b0;
         iosel_out <= 1'b0;
         iosel_oe <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         rdata <= '0;
      end else if (clk_en) begin
         done <= 1'b0;
         case (state)
            st_idle: begin
               // wait for a free bus and own the mastership
               if (req && owner == own_cpu && !sync_in) begin
                  state <= st_addr;
                  busy <= 1'b1;
                  wr_cyc <= req_write;
                  dal_out <= req_addr;
                  dal_oe <= '1;
                  wtbt_out <= req_write;
                  wtbt_oe <= req_write;
                  iosel_out <= in_io_page(req_addr);
                  iosel_oe <= in_io_page(req_addr);
               end
            end
            st_addr: begin
               // address stable one clock before sync
               sync_out <= 1'b1;
               sync_oe <= 1'b1;
               state <= st_sync;
            end
            st_sync: begin
               // drop address, present data or strobe input
               wtbt_out <= 1'b0;
               wtbt_oe <= 1'b0;
               iosel_out <= 1'b0;
               iosel_oe <= 1'b0;
               if (wr_cyc) begin
                  dal_out <= {6'h00, req_wdata};
                  dout_out <= 1'b1;
                  dout_oe <= 1'b1;
               end else begin
                  dal_oe <= '0;
                  dal_out <= '0;
                  din_out <= 1'b1;
                  din_oe <= 1'b1;
               end
               state <= st_strobe;
            end
            st_strobe: begin
               // interlock: no progress without slave reply, except abort on watchdog expiry
               if (tmo_hit) begin
                  state <= st_abort;
               end else if (reply_in) begin
                  if (!wr_cyc) begin
                     rdata <= dal_in[17:0];
                  end
                  din_out <= 1'b0;
                  din_oe <= 1'b0;
                  dout_out <= 1'b0;
                  dout_oe <= 1'b0;
                  state <= st_release;
               end
            end
            st_release: begin
               // end cycle after slave removes reply
               if (!reply_in) begin
                  dal_out <= '0;
                  dal_oe <= '0;
                  sync_out <= 1'b0;
                  sync_oe <= 1'b0;
                  busy <= 1'b0;
                  done <= 1'b1;
                  state <= st_idle;
               end
            end
            st_abort: begin
               // timeout: let go of every line at once
               dal_out <= '0;
               dal_oe <= '0;
               din_out <= 1'b0;
               din_oe <= 1'b0;
               dout_out <= 1'b0;
               dout_oe <= 1'b0;
               sync_out <= 1'b0;
               sync_oe <= 1'b0;
               busy <= 1'b0;
               state <= st_idle;
            end
            default: begin
               state <= st_idle;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // timeout watchdog and sticky error
   // ----------------------------------------------------------------------
   assign tmo_start = (state != st_strobe);

   reply_timer #(
      .W(`TMO_W)
   ) u_timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_en(clk_en),
      .start(tmo_start),
      .run(!reply_in),
      .limit(limit_eff),
      .expired(tmo_hit)
   );

   // set beats clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         timeout_err <= 1'b0;
      end else if (clk_en) begin
         if (state == st_strobe && tmo_hit) begin
            timeout_err <= 1'b1;
         end else if (err_clear) begin
            timeout_err <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   property p_sync_held;
      @(posedge sys_clk) disable iff (rst)
      (state == st_strobe) |-> sync_out;
   endproperty
   a_sync_held: assert property (p_sync_held)
      else $error("sync dropped during transfer");

   property p_start_free;
      @(posedge sys_clk) disable iff (rst)
      (clk_en && state == st_idle && $rose(busy) == 0 && req
       && owner == own_cpu && !sync_in) |=> busy;
   endproperty
   a_start_free: assert property (p_start_free)
      else $error("cycle not started on free bus");

   property p_no_grant_in_cycle;
      @(posedge sys_clk) disable iff (rst)
      busy |-> !(iak_chain_out || dmg_chain_out) || owner != own_cpu;
   endproperty
   a_no_grant_in_cycle: assert property (p_no_grant_in_cycle)
      else $error("grant while cpu cycle active");

   property p_write_line;
      @(posedge sys_clk) disable iff (rst)
      (state == st_addr) |-> (wtbt_out == wr_cyc);
   endproperty
   a_write_line: assert property (p_write_line)
      else $error("write line wrong in address phase");

   property p_io_line;
      @(posedge sys_clk) disable iff (rst)
      (state == st_addr) |-> (iosel_out == in_io_page(dal_out));
   endproperty
   a_io_line: assert property (p_io_line)
      else $error("io select wrong");

   sequence s_stuck;
      (state == st_strobe && tmo_hit && clk_en);
   endsequence
   property p_abort;
      @(posedge sys_clk) disable iff (rst)
      s_stuck |=> timeout_err ##1 (!sync_out && dal_oe == '0);
   endproperty
   a_abort: assert property (p_abort)
      else $error("timeout did not release bus");

   property p_limit_floor;
      @(posedge sys_clk) disable iff (rst)
      limit_eff >= TIMEOUT_CYC;
   endproperty
   a_limit_floor: assert property (p_limit_floor)
      else $error("timeout below floor");

   property p_wait_reply;
      @(posedge sys_clk) disable iff (rst)
      (state == st_strobe && !reply_in && !tmo_hit) |=> state == st_strobe
         || !clk_en;
   endproperty
   a_wait_reply: assert property (p_wait_reply)
      else $error("strobe ended without reply");
endmodule
`default_nettype wire

//--- dv/bp_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "bp_bus_defs.svh"

// ----------------------------------------------------------------------
// slave model: one memory and one io page responder
// ----------------------------------------------------------------------
module bp_slave_model (
   input wire logic sys_clk,
   input wire logic sync,
   input wire logic din,
   input wire logic dout,
   input wire logic iosel,
   input wire logic mute,
   input wire logic [3:0] lat,
   input wire logic [`ADDR_W-1:0] dal,
   output logic [`ADDR_W-1:0] dal_drv,
   output logic reply
);
   logic [15:0] mem [16]; // tiny store, aliased on bits 4:1
   logic [`ADDR_W-1:0] adr; // address latched at sync
   logic sel; // selected for this cycle
   logic sync_d; // sync seen last edge
   logic [3:0] cnt; // reply delay

   initial begin
      reply = 1'b0;
      dal_drv = '0;
      adr = '0;
      sel = 1'b0;
      sync_d = 1'b0;
      cnt = '0;
   end

   // latch on sync rise; io page answers only with iosel, memory without
   always @(posedge sys_clk) begin
      sync_d <= sync;
      if (sync && !sync_d) begin
         adr <= dal;
         sel <= (iosel == (dal >= `IO_PAGE_TOP)) && !mute;
      end
      if (!sync) begin
         sel <= 1'b0;
      end
      // reply only after a strobe, after lat extra cycles
      if (sel && (din || dout) && !reply) begin
         cnt <= cnt + 4'h1;
         if (cnt == lat) begin
            reply <= 1'b1;
            cnt <= '0;
            if (dout) begin
               mem[adr[4:1]] <= dal[15:0];
            end
            if (din) begin
               dal_drv <= {6'h00, mem[adr[4:1]]};
            end
         end
      end
      // strobe gone: drop reply and let termination negate the lines
      if (reply && !din && !dout) begin
         reply <= 1'b0;
         dal_drv <= '0;
      end
   end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bp_bus_defs.svh"

// ----------------------------------------------------------------------
// bench top: master against slave model
// ----------------------------------------------------------------------
module tb_top;
   import bp_bus_pkg::*;
   localparam logic [11:0] tmo = 12'h014; // short timeout, 20 cycles
   logic sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1;
   logic req = 1'b0, req_write = 1'b0, err_clear = 1'b0;
   logic [21:0] req_addr = '0;
   logic [15:0] req_wdata = '0, s = 16'h46c2; // seed 18114
   logic dma_request = 1'b0, intr_request = 1'b0, sack_in = 1'b0;
   logic ext_sync = 1'b0, mute = 1'b0; // other master, dead slave
   logic [3:0] lat = '0;
   logic busy, done, timeout_err, dma_granted, iak_chain_out;
   logic dmg_chain_out, sync_out, sync_oe, din_out, din_oe, dout_out;
   logic dout_oe, wtbt_out, wtbt_oe, iosel_out, iosel_oe, reply;
   logic [17:0] rdata;
   logic [21:0] dal_out, dal_oe, s_dal, dal_w, a;
   logic sync_w;
   int n_mismatch = 0, n_checks = 0, i;

   // wired-or of open-collector drivers, 1 = line low
   assign dal_w = (dal_oe & dal_out) | s_dal;
   assign sync_w = (sync_oe & sync_out) | ext_sync;

   always #4 sys_clk = ~sys_clk;

   bp_bus_master #(.TIMEOUT_CYC(tmo)) bp_bus_master_inst (
      .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .req(req),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .tmo_limit(tmo), .err_clear(err_clear), .dma_request(dma_request),
      .intr_request(intr_request), .busy(busy), .done(done),
      .rdata(rdata), .timeout_err(timeout_err), .dma_granted(dma_granted),
      .dal_in(dal_w), .dal_out(dal_out), .dal_oe(dal_oe), .sync_in(sync_w),
      .sync_out(sync_out), .sync_oe(sync_oe), .din_out(din_out),
      .din_oe(din_oe), .dout_out(dout_out), .dout_oe(dout_oe),
      .wtbt_out(wtbt_out), .wtbt_oe(wtbt_oe), .iosel_out(iosel_out),
      .iosel_oe(iosel_oe), .reply_in(reply), .sack_in(sack_in),
      .iak_chain_out(iak_chain_out), .dmg_chain_out(dmg_chain_out));

   bp_slave_model bp_slave_model_inst (
      .sys_clk(sys_clk), .sync(sync_w), .din(din_oe & din_out),
      .dout(dout_oe & dout_out), .iosel(iosel_oe & iosel_out),
      .mute(mute), .lat(lat), .dal(dal_w), .dal_drv(s_dal),
      .reply(reply));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   // io page is the top 8k of the 22-bit space
   function automatic logic io_of(input logic [21:0] v);
      return v >= 22'h3fe000;
   endfunction

   // wide enough for the 44-bit enable plus address compare
   task automatic check(input string what, input logic [47:0] seen,
                        input logic [47:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // one bus cycle; d is write data or expected read data
   task automatic cycle(input logic w, input logic [21:0] ad,
                        input logic [15:0] d, input logic exp_to);
      int k;
      @(negedge sys_clk);
      req = 1'b1;
      req_write = w;
      req_addr = ad;
      req_wdata = d;
      for (k = 0; k < 20 && busy !== 1'b1; k++) @(negedge sys_clk);
      req = 1'b0;
      check("busy", busy, 1'b1);
      check("dal addr", {dal_oe, dal_out}, {22'h3fffff, ad});
      check("wtbt", wtbt_oe & wtbt_out, w);
      check("iosel", iosel_oe & iosel_out, io_of(ad));
      for (k = 0; k < 100 && done !== 1'b1 && timeout_err !== 1'b1; k++)
         @(negedge sys_clk);
      if (k == 100) begin
         n_mismatch++; // hung cycle: counted, verdict at the end
         return;
      end
      check("timeout", timeout_err, exp_to);
      check("done", done, !exp_to);
      if (!w && !exp_to) check("rdata", rdata, {2'b00, d});
      if (exp_to) begin
         check("tmo time", (k >= 20) && (k < 30), 1'b1);
         @(negedge sys_clk);
         check("released", {sync_oe, din_oe, dout_oe, dal_oe}, '0);
      end
   endtask

   // request held while the bus is not ours: must be ignored
   task automatic refused();
      @(negedge sys_clk);
      req = 1'b1;
      repeat (6) @(negedge sys_clk);
      check("refused", busy, 1'b0);
      req = 1'b0;
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      check("reset", {busy, sync_oe, dal_oe, timeout_err}, '0);
      // random write then read back, corners first at slowest reply
      for (i = 0; i < 16; i++) begin
         s = lfsr(s);
         a = {s[5:0], lfsr(s)};
         if (s[0]) a = a | 22'h3fe000;
         if (i == 0) a = 22'h3fdfff;
         if (i == 1) a = 22'h3fe000;
         if (i == 2) a = 22'h3fffff;
         lat = (i < 3) ? 4'hf : s[3:0];
         cycle(1'b1, a, s, 1'b0);
         cycle(1'b0, a, s, 1'b0);
      end
      // dead slave: abort, sticky error, then cleared
      mute = 1'b1;
      cycle(1'b0, 22'h000100, 16'h0000, 1'b1);
      repeat (3) @(negedge sys_clk);
      check("sticky", timeout_err, 1'b1);
      err_clear = 1'b1;
      @(negedge sys_clk);
      err_clear = 1'b0;
      @(negedge sys_clk);
      check("cleared", timeout_err, 1'b0);
      mute = 1'b0;
      // clock enable low: a request must stay frozen out
      clk_en = 1'b0;
      refused();
      clk_en = 1'b1;
      // another party holds sync
      ext_sync = 1'b1;
      refused();
      ext_sync = 1'b0;
      // dma device takes the bus, cpu locked out until sack drops
      dma_request = 1'b1;
      repeat (4) @(negedge sys_clk);
      check("dmg", {dmg_chain_out, dma_granted}, 2'b11);
      sack_in = 1'b1;
      dma_request = 1'b0;
      refused();
      sack_in = 1'b0;
      repeat (4) @(negedge sys_clk);
      cycle(1'b1, 22'h000010, 16'h1234, 1'b0);
      // both chains requested at once: interrupt wins
      intr_request = 1'b1;
      dma_request = 1'b1;
      repeat (4) @(negedge sys_clk);
      check("chain", {iak_chain_out, dmg_chain_out}, 2'b10);
      // acknowledge withdrawn: waiting dma request is granted next
      intr_request = 1'b0;
      repeat (4) @(negedge sys_clk);
      check("chain drop", {iak_chain_out, dmg_chain_out}, 2'b01);
      end_of_test();
   end
endmodule
`default_nettype wire
